// >>> hw/tap_map.vh
// constants of the boundary-scan test access port
`ifndef TAP_MAP_VH
`define TAP_MAP_VH

// scan register sizes
`define IR_W           3
`define ID_W           32
`define BSR_W          107

// instruction codes
`define IR_EXTEST      3'h0
`define IR_IDCODE      3'h1
`define IR_SAMPLE_Z    3'h2
`define IR_RSVD_3      3'h3
`define IR_SAMPLE      3'h4
`define IR_RSVD_5      3'h5
`define IR_RSVD_6      3'h6
`define IR_BYPASS      3'h7

// value loaded by capture-instruction, two low bits 01
`define IR_CAPTURE     3'h1

// identification register field positions
`define ID_REV_HI      31
`define ID_REV_LO      29
`define ID_PART_HI     28
`define ID_PART_LO     12
`define ID_VEND_HI     11
`define ID_VEND_LO     1
`define ID_PRESENT     0

// boundary cell that gates the output bus under external test
`define BSR_TRI_BIT    47

`endif

// >>> hw/bscan_reg.v
// boundary scan register: capture/shift stage and parallel update latch
`timescale 1ns/1ps
`default_nettype none
`include "tap_map.vh"

module bscan_reg #(
  parameter WIDTH   = `BSR_W,
  parameter TRI_BIT = `BSR_TRI_BIT
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst_n,
  input  wire             ce,
  // controls: tlr a level held in test-logic-reset, the others one-cycle strobes on a test clock rise
  input  wire             tlr,
  input  wire             capture,
  input  wire             shift,
  input  wire             update,
  // serial and parallel data
  input  wire             tdi,
  input  wire [WIDTH-1:0] par_in,
  output reg              sout,
  output reg  [WIDTH-1:0] upd_r
);

  reg [WIDTH-1:0] sr_r;

  // update latch resets low except the output-enable cell, which is preset high
  localparam [WIDTH-1:0] UPD_RST = {{(WIDTH-1){1'b0}}, 1'b1} << TRI_BIT;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sr_r  <= {WIDTH{1'b0}};
      upd_r <= UPD_RST;
      sout  <= 1'b0;
    end else if (ce) begin
      if (tlr) begin
        upd_r <= UPD_RST;
      end else if (update) begin
        upd_r <= sr_r;
      end
      if (capture) begin
        sr_r <= par_in;
        sout <= par_in[0];
      end else if (shift) begin
        // msb faces the serial input, lsb the serial output
        sr_r <= {tdi, sr_r[WIDTH-1:1]};
        sout <= sr_r[1];
      end
    end
  end

endmodule
`default_nettype wire

// >>> hw/tap_top.v
// boundary-scan test access port controller with instruction and data registers
`timescale 1ns/1ps
`default_nettype none
`include "tap_map.vh"

// Functional notes
// - ir 3, bypass 1, id 32, boundary 107 bits
// - code 001 selects fixed identification register
// - code 000 captures ring into boundary register
// - code 010 samples, scans, tristates output bus
// - code 100 samples and scans, memory undisturbed
// - code 111 selects single-bit bypass register
// - id fields: revision, part type, vendor
// - id bit zero always reads one
// - state advances on tms at test clock rise
// - five tms-high rises reset test logic
// - sample input on rise, drive output on fall
// - reset and test-logic-reset load identification instruction
// - capture-instruction loads 01 into low bits
module tap_top #(
  parameter [2:0]  ID_REV  = 3'h1,      // arbitrary value
  parameter [16:0] ID_PART = 17'h0abcd, // arbitrary value
  parameter [10:0] ID_VEND = 11'h055    // arbitrary value
) (
  // clock, reset, enable
  input  wire              clk,
  input  wire              rstn,
  input  wire              ce,
  // test port pins
  input  wire              tck,
  input  wire              tms,
  input  wire              tdi,
  output reg               tdo,
  output reg               tdo_oe_n,
  // boundary cells towards the memory pins
  input  wire [`BSR_W-1:0] pin_in,
  output wire [`BSR_W-1:0] pin_drive,
  output reg               extest_r,
  output reg               out_hiz_r,
  // current instruction
  output reg  [`IR_W-1:0]  ir_r
);

  localparam [3:0] S_TLR    = 4'h0;
  localparam [3:0] S_RTI    = 4'h1;
  localparam [3:0] S_SEL_DR = 4'h2;
  localparam [3:0] S_CAP_DR = 4'h3;
  localparam [3:0] S_SH_DR  = 4'h4;
  localparam [3:0] S_EX1_DR = 4'h5;
  localparam [3:0] S_PA_DR  = 4'h6;
  localparam [3:0] S_EX2_DR = 4'h7;
  localparam [3:0] S_UP_DR  = 4'h8;
  localparam [3:0] S_SEL_IR = 4'h9;
  localparam [3:0] S_CAP_IR = 4'ha;
  localparam [3:0] S_SH_IR  = 4'hb;
  localparam [3:0] S_EX1_IR = 4'hc;
  localparam [3:0] S_PA_IR  = 4'hd;
  localparam [3:0] S_EX2_IR = 4'he;
  localparam [3:0] S_UP_IR  = 4'hf;

  localparam [`ID_W-1:0] ID_CODE = {ID_REV, ID_PART, ID_VEND, 1'b1};

  // reset release through two flip-flops
  reg rst_s1_r;
  reg rst_n_s;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_r <= 1'b0;
      rst_n_s  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_s  <= rst_s1_r;
    end
  end

  // three-stage pin synchronisers, a change counts once stages two and three agree
  reg [2:0] tck_s_r;
  reg [2:0] tms_s_r;
  reg [2:0] tdi_s_r;
  reg       tck_f_r;
  reg       tms_f_r;
  reg       tdi_f_r;
  wire      tck_rise = (tck_s_r[1] == tck_s_r[2]) & tck_s_r[2] & ~tck_f_r;
  wire      tck_fall = (tck_s_r[1] == tck_s_r[2]) & ~tck_s_r[2] & tck_f_r;

  always @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      tck_s_r <= 3'h0;
      tms_s_r <= 3'h7;
      tdi_s_r <= 3'h0;
      tck_f_r <= 1'b0;
      tms_f_r <= 1'b1;
      tdi_f_r <= 1'b0;
    end else if (ce) begin
      tck_s_r <= {tck_s_r[1:0], tck};
      tms_s_r <= {tms_s_r[1:0], tms};
      tdi_s_r <= {tdi_s_r[1:0], tdi};
      if (tck_s_r[1] == tck_s_r[2]) begin
        tck_f_r <= tck_s_r[2];
      end
      if (tms_s_r[1] == tms_s_r[2]) begin
        tms_f_r <= tms_s_r[2];
      end
      if (tdi_s_r[1] == tdi_s_r[2]) begin
        tdi_f_r <= tdi_s_r[2];
      end
    end
  end

  // controller next state
  function [3:0] tap_next;
    input [3:0] st;
    input       m;
    begin
      case (st)
        S_TLR:    tap_next = m ? S_TLR    : S_RTI;
        S_RTI:    tap_next = m ? S_SEL_DR : S_RTI;
        S_SEL_DR: tap_next = m ? S_SEL_IR : S_CAP_DR;
        S_CAP_DR: tap_next = m ? S_EX1_DR : S_SH_DR;
        S_SH_DR:  tap_next = m ? S_EX1_DR : S_SH_DR;
        S_EX1_DR: tap_next = m ? S_UP_DR  : S_PA_DR;
        S_PA_DR:  tap_next = m ? S_EX2_DR : S_PA_DR;
        S_EX2_DR: tap_next = m ? S_UP_DR  : S_SH_DR;
        S_UP_DR:  tap_next = m ? S_SEL_DR : S_RTI;
        S_SEL_IR: tap_next = m ? S_TLR    : S_CAP_IR;
        S_CAP_IR: tap_next = m ? S_EX1_IR : S_SH_IR;
        S_SH_IR:  tap_next = m ? S_EX1_IR : S_SH_IR;
        S_EX1_IR: tap_next = m ? S_UP_IR  : S_PA_IR;
        S_PA_IR:  tap_next = m ? S_EX2_IR : S_PA_IR;
        S_EX2_IR: tap_next = m ? S_UP_IR  : S_SH_IR;
        default:  tap_next = m ? S_SEL_DR : S_RTI;
      endcase
    end
  endfunction

  // instructions that put the boundary register on the scan path
  function uses_bsr;
    input [`IR_W-1:0] ir;
    begin
      uses_bsr = (ir == `IR_EXTEST) | (ir == `IR_SAMPLE_Z) | (ir == `IR_SAMPLE);
    end
  endfunction

  reg [3:0]       state_r;
  reg [`IR_W-1:0] ir_sr_r;
  reg [`ID_W-1:0] id_sr_r;
  reg             byp_r;
  wire            bsr_sout;

  wire in_tlr  = (state_r == S_TLR);
  wire cap_dr  = tck_rise & (state_r == S_CAP_DR);
  wire sh_dr   = tck_rise & (state_r == S_SH_DR);
  wire up_dr   = tck_rise & (state_r == S_UP_DR);
  wire bsr_sel = uses_bsr(ir_r);

  bscan_reg #(
    .WIDTH   (`BSR_W),
    .TRI_BIT (`BSR_TRI_BIT)
  ) u_bsr (
    .clk     (clk),
    .rst_n   (rst_n_s),
    .ce      (ce),
    .tlr     (in_tlr),
    .capture (cap_dr & bsr_sel),
    .shift   (sh_dr & bsr_sel),
    .update  (up_dr & bsr_sel),
    .tdi     (tdi_f_r),
    .par_in  (pin_in),
    .sout    (bsr_sout),
    .upd_r   (pin_drive)
  );

  // controller, instruction, identification and bypass registers
  always @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      state_r <= S_TLR;
      ir_r    <= `IR_IDCODE;
      ir_sr_r <= `IR_CAPTURE;
      id_sr_r <= {`ID_W{1'b0}};
      byp_r   <= 1'b0;
    end else if (ce) begin
      if (tck_rise) begin
        state_r <= tap_next(state_r, tms_f_r);
        case (state_r)
          S_CAP_IR: ir_sr_r <= `IR_CAPTURE;
          S_SH_IR:  ir_sr_r <= {tdi_f_r, ir_sr_r[`IR_W-1:1]};
          S_UP_IR:  ir_r    <= ir_sr_r;
          S_CAP_DR: begin
            id_sr_r <= ID_CODE;
            byp_r   <= 1'b0;
          end
          S_SH_DR: begin
            id_sr_r <= {tdi_f_r, id_sr_r[`ID_W-1:1]};
            byp_r   <= tdi_f_r;
          end
          default: ir_r <= in_tlr ? `IR_IDCODE : ir_r;
        endcase
      end else if (in_tlr) begin
        ir_r <= `IR_IDCODE;
      end
    end
  end

  // serial output and its enable changed on the test clock fall, output-bus control every enabled cycle
  reg tdo_nxt;
  always @* begin
    if (state_r == S_SH_IR) begin
      tdo_nxt = ir_sr_r[0];
    end else if (ir_r == `IR_IDCODE) begin
      tdo_nxt = id_sr_r[0];
    end else if (bsr_sel) begin
      tdo_nxt = bsr_sout;
    end else begin
      // bypass and reserved codes use the one-bit path
      tdo_nxt = byp_r;
    end
  end

  always @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      tdo       <= 1'b0;
      tdo_oe_n  <= 1'b1;
      extest_r  <= 1'b0;
      out_hiz_r <= 1'b0;
    end else if (ce) begin
      if (tck_fall) begin
        tdo      <= tdo_nxt;
        tdo_oe_n <= ~((state_r == S_SH_IR) | (state_r == S_SH_DR));
      end
      extest_r  <= (ir_r == `IR_EXTEST);
      out_hiz_r <= (ir_r == `IR_SAMPLE_Z) |
                   ((ir_r == `IR_EXTEST) & ~pin_drive[`BSR_TRI_BIT]);
    end
  end

endmodule
`default_nettype wire

// >>> dv/tap_top_properties.sv
// concurrent checks on the test access port outputs
`timescale 1ns/1ps
`default_nettype none
`include "tap_map.vh"
module tap_props (
  // clock and reset
  input wire logic              clk,
  input wire logic              rstn,
  // link and outputs
  input wire logic              tck,
  input wire logic              tms,
  input wire logic              tdo,
  input wire logic              tdo_oe_n,
  input wire logic [`BSR_W-1:0] pin_drive,
  input wire logic              extest_r,
  input wire logic              out_hiz_r,
  input wire logic [`IR_W-1:0]  ir_r
);
  localparam logic [`BSR_W-1:0] RSTV = 107'h1 << `BSR_TRI_BIT;
  logic       tck_q;
  logic [2:0] ones_cnt;
  // counts successive test clock rises seen with mode select high, saturating at 7
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tck_q    <= 1'b0;
      ones_cnt <= 3'h0;
    end else begin
      tck_q <= tck;
      if (tck && !tck_q)
        ones_cnt <= !tms ? 3'h0 : (ones_cnt == 3'h7) ? ones_cnt : ones_cnt + 3'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence five_ones;
    $rose(ones_cnt == 3'h5);
  endsequence
  sequence preset_seen;
    ir_r == `IR_IDCODE && pin_drive == RSTV;
  endsequence
  a_five_ones_reset: assert property (five_ones |-> ##[1:8] preset_seen)
    else $error("test logic reset missed");
  a_tdo_after_fall: assert property ($changed(tdo) |-> !$past(tck, 2))
    else $error("tdo moved outside a falling edge");
  a_oe_after_fall: assert property ($changed(tdo_oe_n) |-> !$past(tck, 2))
    else $error("tdo enable moved outside a falling edge");
  a_ir_on_rise: assert property ($changed(ir_r) |-> $past(tck, 2) || $past(tck, 3))
    else $error("instruction moved outside a rising edge");
  a_extest_track: assert property (ir_r == `IR_EXTEST |=> extest_r)
    else $error("external test flag missing");
  a_hiz_follow: assert property (##1 out_hiz_r == ($past(ir_r) == `IR_SAMPLE_Z
    || ($past(ir_r) == `IR_EXTEST && !$past(pin_drive[`BSR_TRI_BIT]))))
    else $error("output bus tristate wrong");
  a_hiz_hold: assert property ((ir_r == `IR_SAMPLE_Z) [*2] |-> out_hiz_r)
    else $error("tristate instruction did not float bus");
  a_latch_gated: assert property ($changed(pin_drive) |-> pin_drive == RSTV
    || $past(ir_r) inside {`IR_EXTEST, `IR_SAMPLE_Z, `IR_SAMPLE})
    else $error("update latch moved under wrong instruction");
endmodule
bind tap_top tap_props u_props (.clk(clk), .rstn(rstn), .tck(tck), .tms(tms), .tdo(tdo),
  .tdo_oe_n(tdo_oe_n), .pin_drive(pin_drive), .extest_r(extest_r),
  .out_hiz_r(out_hiz_r), .ir_r(ir_r));
`default_nettype wire

// >>> dv/scan_ctl.sv
// board test controller model driving the link
`timescale 1ns/1ps
`default_nettype none
module scan_ctl (
  // link
  output var logic tck,
  output var logic tms,
  output var logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe_n
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // one test clock period, tdo taken just before the rise
  task step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    // a released tdo line reads back inverted, so an idle driver cannot pass
    #79 q = tdo_oe_n ? ~tdo : tdo;
    #1 tck = 1'b1;
    #120 tck = 1'b0;
    #120;
  endtask
  // capture, shift n bits lsb first, update, back to idle
  task scan(input logic ir, input logic [143:0] v, input int n, output logic [143:0] o);
    logic q;
    o = '0;
    step(1'b1, ~tdi, q);
    if (ir)
      step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
    step(1'b0, ~tdi, q);
    for (int i = 0; i < n; i++)
      step(i == n - 1, v[i], o[i]);
    step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
  endtask
endmodule
`default_nettype wire

// >>> dv/tap_top_tb.sv
// self-checking bench for the test access port
`timescale 1ns/1ps
`default_nettype none
`include "tap_map.vh"
module tap_top_tb;
  localparam logic [2:0]  REV  = 3'h5;     // arbitrary value
  localparam logic [16:0] PART = 17'h1234e; // arbitrary value
  localparam logic [10:0] VEND = 11'h2a6;   // arbitrary value
  localparam logic [31:0] IDV  = {REV, PART, VEND, 1'b1};
  localparam logic [`BSR_W-1:0] PAT  = {1'b1, {53{2'h1}}};
  localparam logic [`BSR_W-1:0] RSTV = 107'h1 << `BSR_TRI_BIT;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic [`BSR_W-1:0] pin_in = PAT;
  wire logic tck, tms, tdi, tdo, tdo_oe_n, extest_r, out_hiz_r;
  wire logic [`BSR_W-1:0] pin_drive;
  wire logic [`IR_W-1:0]  ir_r;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  int len;
  logic [143:0] o, e;
  always #20 clk = ~clk;
  tap_top #(.ID_REV(REV), .ID_PART(PART), .ID_VEND(VEND)) u_dut (.clk(clk), .rstn(rstn),
    .ce(ce), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
    .pin_in(pin_in), .pin_drive(pin_drive), .extest_r(extest_r),
    .out_hiz_r(out_hiz_r), .ir_r(ir_r));
  scan_ctl u_ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n));
  task check(input logic [143:0] seen, input logic [143:0] exp, input string msg);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task wrap_up;
    $display("checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      failures++;
      wrap_up;
    end
  end
  initial begin
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    repeat (6) @(negedge clk);
    check(ir_r, `IR_IDCODE, "reset instruction");
    check(pin_drive, RSTV, "reset update latch");
    check(tdo_oe_n, 1'b1, "tdo idle");
    u_ctl.step(1'b0, 1'b1, o[0]);
    u_ctl.scan(1'b0, '0, 32, o);
    check(o, IDV, "id code");
    $display("test id done");
    for (int c = 0; c < 8; c++) begin
      if (c == 3 || c == 5 || c == 6) continue;
      u_ctl.scan(1'b1, c, 3, o);
      check(o, `IR_CAPTURE, "capture instruction");
      check(ir_r, c[2:0], "current instruction");
      len = (c == 1) ? `ID_W : (c == 0 || c == 2 || c == 4) ? `BSR_W : 1;
      e = (c == 1) ? IDV : (len == 1) ? '0 : PAT;
      e[len] = 1'b1;
      u_ctl.scan(1'b0, 1, len + 1, o);
      check(o, e, "selected data path");
      check(out_hiz_r, c == 0 || c == 2, "output bus tristate");
      check(extest_r, c == 0, "external test flag");
      check(pin_drive, '0, "update latch");
    end
    $display("test paths done");
    u_ctl.step(1'b1, ~tdi, o[0]);
    u_ctl.step(1'b0, ~tdi, o[0]);
    u_ctl.step(1'b0, ~tdi, o[0]);
    repeat (4) u_ctl.step(1'b1, ~tdi, o[0]);
    check(ir_r, `IR_BYPASS, "no reset after four rises");
    u_ctl.step(1'b1, ~tdi, o[0]);
    repeat (4) @(negedge clk);
    check(ir_r, `IR_IDCODE, "test logic reset");
    check(pin_drive, RSTV, "update latch preset");
    $display("test reset done");
    wrap_up;
  end
endmodule
`default_nettype wire
